//--- design/pfio_top.sv
// port 4 lines 5 to 0 and port 5 general-purpose I/O with Avalon-MM registers
// Operation
// - expanded: line 5 drives address or io strobe by select; single chip: direction.
// - expanded: line 4 always drives store strobe; single chip follows direction.
// - expanded: line 3 always drives read strobe; single chip follows direction.
// - lines 2, 1 follow direction and feed interrupt inputs 0, 1 when enabled.
// - line 0 follows direction and feeds interrupt input 2 when enabled.
// - both trigger selects set make line 0 the converter trigger.
// - port 5 has three lines, each with direction and latch bits 2 to 0.
// - port 5 pin selection is the same in every operating mode.
// - port 5 direction register is 8-bit write-only, reads undefined, bits 7-3 reserved.
// - port 5 direction one makes an output, zero an input.
// - port 5 direction loads F8 on reset and hardware standby, holds otherwise.
// - serial unit idle: two-wire enable, direction and latch set port 5 lines.
// - port 5 data register is 8-bit read/write holding line 2-0 outputs.
// - port 5 read gives latch for outputs, pin level for inputs.
// - port 5 data bits 7 to 3 ignore writes and read as one.
// - port 5 data loads F8 on reset and hardware standby, holds otherwise.
// - port 4 read gives latch for outputs, pin level for inputs.
// - mode 1 or bus enable set is expanded; else single chip.
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module pfio_top #(
   parameter int ADDR_W = pfio_pkg::ADDR_W
) (
   // clock, reset, enable
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic HW_STANDBY,
   // Avalon-MM slave
   input wire logic [ADDR_W-1:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   // bus-control strobes and serial state
   input wire pfio_pkg::pfio_strobe_t STROBES,
   input wire logic SERIAL0_IDLE,
   // port 4 lines 5 to 0
   input wire logic [pfio_pkg::P4_LINES-1:0] P4_IN,
   output logic [pfio_pkg::P4_LINES-1:0] P4_OUT,
   output logic [pfio_pkg::P4_LINES-1:0] P4_OE,
   // port 5 lines 2 to 0
   input wire logic [pfio_pkg::P5_LINES-1:0] P5_IN,
   output logic [pfio_pkg::P5_LINES-1:0] P5_OUT,
   output logic [pfio_pkg::P5_LINES-1:0] P5_OE,
   // to interrupt controller and converter, active low
   output logic [2:0] EXT_INT_PIN_N,
   output logic CONVERTER_TRIGGER_PIN_N
);
   pfio_pkg::pfio_state_t s;
   pfio_pkg::pfio_state_t next_s;
   logic expanded;
   logic [pfio_pkg::P4_LINES-1:0] p4_mux_out;
   logic [pfio_pkg::P4_LINES-1:0] p4_mux_oe;
   logic [pfio_pkg::P5_LINES-1:0] p5_mux_out;
   logic [pfio_pkg::P5_LINES-1:0] p5_mux_oe;
   logic [pfio_pkg::P5_LINES-1:0] p5_rd;
   logic [15:0] idx;
   logic req;
   logic [31:0] rd_val;
   logic [pfio_pkg::P4_LINES-1:0] p4_rd;

   // ==========================================================
   // mode decode and pin muxes
   // ==========================================================
   // mode 1 is always expanded
   assign expanded = (s.cfg.mode == pfio_pkg::MODE_EXP_ONLY) | s.cfg.external_bus_enable;

   pfio_p4_mux #(
      .LINES(pfio_pkg::P4_LINES)
   ) u_p4_mux (
      .expanded(expanded),
      .io_strobe_select(s.cfg.io_strobe_select),
      .strobes(STROBES),
      .dir(s.p4_dir),
      .latch(s.p4_latch),
      .out(p4_mux_out),
      .oe(p4_mux_oe)
   );

   // no mode input reaches port 5
   pfio_p5_mux #(
      .LINES(pfio_pkg::P5_LINES)
   ) u_p5_mux (
      .two_wire_enable(s.cfg.two_wire_enable),
      .serial_idle(SERIAL0_IDLE),
      .dir(s.p5_dir[pfio_pkg::P5_LINES-1:0]),
      .latch(s.p5_latch),
      .pin(P5_IN),
      .out(p5_mux_out),
      .oe(p5_mux_oe),
      .rd(p5_rd)
   );

   // ==========================================================
   // register read decode
   // ==========================================================
   assign idx = AVS_ADDRESS[17:2];
   assign req = AVS_READ | AVS_WRITE;

   // latch for outputs, pin for inputs
   assign p4_rd = (s.p4_dir & s.p4_latch) | (~s.p4_dir & P4_IN);

   always_comb begin
      rd_val = 32'h0000_0000;
      case (idx)
         pfio_pkg::P4_DATA_IDX: begin
            rd_val[pfio_pkg::P4_LINES-1:0] = p4_rd;
         end
         pfio_pkg::P5_DATA_IDX: begin
            rd_val[7:0] = {pfio_pkg::P5_RSVD_ONES, p5_rd};
         end
         pfio_pkg::CFG_IDX: begin
            rd_val[pfio_pkg::CFG_W-1:0] = s.cfg;
         end
         // direction registers have no read path
         default: begin
            rd_val = 32'h0000_0000;
         end
      endcase
   end

   // ==========================================================
   // next state
   // ==========================================================
   always_comb begin
      next_s = s;
      if (CE) begin
         next_s.p4_out = p4_mux_out;
         next_s.p4_oe = p4_mux_oe;
         next_s.p5_out = p5_mux_out;
         next_s.p5_oe = p5_mux_oe;
         // pin level taken regardless of direction
         // interrupt inputs 0 and 1 from lines 2 and 1
         next_s.ext_int_n[0] = s.cfg.ext_int_enable[0] ? P4_IN[2] : 1'b1;
         next_s.ext_int_n[1] = s.cfg.ext_int_enable[1] ? P4_IN[1] : 1'b1;
         // interrupt input 2 from line 0
         next_s.ext_int_n[2] = s.cfg.ext_int_enable[2] ? P4_IN[0] : 1'b1;
         next_s.trig_n = (s.cfg.trigger_select_hi & s.cfg.trigger_select_lo) ? P4_IN[0] : 1'b1;

         // one-cycle answer: drop waitrequest, then act on the accepting edge
         if (req && !s.ack) begin
            next_s.ack = 1'b1;
            next_s.waitreq = 1'b0;
            next_s.rdata = AVS_READ ? rd_val : 32'h0000_0000;
         end else if (req && s.ack) begin
            next_s.ack = 1'b0;
            next_s.waitreq = 1'b1;
            if (AVS_WRITE && AVS_BYTEENABLE[0]) begin
               case (idx)
                  pfio_pkg::P4_DIR_IDX: begin
                     next_s.p4_dir = AVS_WRITEDATA[pfio_pkg::P4_LINES-1:0];
                  end
                  pfio_pkg::P4_DATA_IDX: begin
                     next_s.p4_latch = AVS_WRITEDATA[pfio_pkg::P4_LINES-1:0];
                  end
                  // only the three line bits are writable
                  pfio_pkg::P5_DIR_IDX: begin
                     next_s.p5_dir = {pfio_pkg::P5_DIR_RST[7:3], AVS_WRITEDATA[2:0]};
                  end
                  pfio_pkg::P5_DATA_IDX: begin
                     next_s.p5_latch = AVS_WRITEDATA[pfio_pkg::P5_LINES-1:0];
                  end
                  pfio_pkg::CFG_IDX: begin
                     if (AVS_BYTEENABLE[1:0] == pfio_pkg::CFG_BE_MASK) begin
                        next_s.cfg = AVS_WRITEDATA[pfio_pkg::CFG_W-1:0];
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end else begin
            next_s.ack = 1'b0;
            next_s.waitreq = 1'b1;
         end
      end
   end

   // ==========================================================
   // state register
   // ==========================================================
   always_ff @(posedge SYS_CLK) begin
      // reset and hardware standby load direction defaults
      if (RST || HW_STANDBY) begin
         s.cfg <= pfio_pkg::CFG_RST;
         s.p4_dir <= pfio_pkg::P4_DIR_RST[pfio_pkg::P4_LINES-1:0];
         s.p4_latch <= pfio_pkg::P4_DATA_RST[pfio_pkg::P4_LINES-1:0];
         s.p5_dir <= pfio_pkg::P5_DIR_RST;
         s.p5_latch <= pfio_pkg::P5_DATA_RST[pfio_pkg::P5_LINES-1:0];
         s.ack <= 1'b0;
         s.waitreq <= 1'b1;
         s.rdata <= 32'h0000_0000;
         s.p4_out <= '0;
         s.p4_oe <= '0;
         s.p5_out <= '0;
         s.p5_oe <= '0;
         s.ext_int_n <= 3'h7;
         s.trig_n <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign AVS_READDATA = s.rdata;
   assign AVS_WAITREQUEST = s.waitreq;
   assign P4_OUT = s.p4_out;
   assign P4_OE = s.p4_oe;
   assign P5_OUT = s.p5_out;
   assign P5_OE = s.p5_oe;
   assign EXT_INT_PIN_N = s.ext_int_n;
   assign CONVERTER_TRIGGER_PIN_N = s.trig_n;

   // ==========================================================
   // assertions
   // ==========================================================
   AST_L5_STROBE: assert property (
      @(posedge SYS_CLK) disable iff (RST || HW_STANDBY)
      (CE && expanded) |=> (P4_OE[5] &&
         P4_OUT[5] == ($past(s.cfg.io_strobe_select) ? $past(STROBES.io_strobe_n)
                                                     : $past(STROBES.address_strobe_n))))
      else $error("line 5 strobe wrong in expanded mode");

   AST_L4_STROBE: assert property (
      @(posedge SYS_CLK) disable iff (RST || HW_STANDBY)
      (CE && expanded) |=> (P4_OE[4] && P4_OUT[4] == $past(STROBES.store_strobe_n)))
      else $error("line 4 store strobe wrong");

   AST_L3_SINGLE: assert property (
      @(posedge SYS_CLK) disable iff (RST || HW_STANDBY)
      (CE && !expanded) |=> (P4_OE[3] == $past(s.p4_dir[3]) && P4_OUT[3] == $past(s.p4_latch[3])))
      else $error("line 3 not plain I/O in single chip");

   AST_L21_DIR: assert property (
      @(posedge SYS_CLK) disable iff (RST || HW_STANDBY)
      CE |=> (P4_OE[2:1] == $past(s.p4_dir[2:1])))
      else $error("lines 2 and 1 enable not from direction");

   AST_INT2: assert property (
      @(posedge SYS_CLK) disable iff (RST || HW_STANDBY)
      (CE && s.cfg.ext_int_enable[2]) |=> (EXT_INT_PIN_N[2] == $past(P4_IN[0])))
      else $error("interrupt 2 not following line 0");

   AST_TRIG: assert property (
      @(posedge SYS_CLK) disable iff (RST || HW_STANDBY)
      (CE && !(s.cfg.trigger_select_hi && s.cfg.trigger_select_lo)) |=> CONVERTER_TRIGGER_PIN_N)
      else $error("trigger active without both selects");

   AST_P5_OE: assert property (
      @(posedge SYS_CLK) disable iff (RST || HW_STANDBY)
      (CE && !s.cfg.two_wire_enable) |=> (P5_OE == $past(s.p5_dir[2:0])))
      else $error("port 5 enable not from direction");

   AST_P5_DIR_RST: assert property (
      @(posedge SYS_CLK) (RST || HW_STANDBY) |=> (s.p5_dir == pfio_pkg::P5_DIR_RST))
      else $error("port 5 direction not loaded on reset");

   AST_P5_READ: assert property (
      @(posedge SYS_CLK) disable iff (RST || HW_STANDBY)
      (CE && AVS_READ && !s.ack && idx == pfio_pkg::P5_DATA_IDX) |=>
         (AVS_READDATA[2:0] == (($past(s.p5_dir[2:0]) & $past(s.p5_latch)) |
                                (~$past(s.p5_dir[2:0]) & $past(P5_IN)))) && !AVS_WAITREQUEST)
      else $error("port 5 read value wrong");

   AST_P5_ONES: assert property (
      @(posedge SYS_CLK) disable iff (RST || HW_STANDBY)
      (CE && AVS_READ && !s.ack && idx == pfio_pkg::P5_DATA_IDX) |=> (AVS_READDATA[7:3] == 5'h1F))
      else $error("port 5 reserved bits not read as one");

   AST_L5_SINGLE: assert property (
      @(posedge SYS_CLK) disable iff (RST || HW_STANDBY)
      (CE && !expanded) |=> (P4_OE[5] == $past(s.p4_dir[5]) && P4_OUT[5] == $past(s.p4_latch[5])))
      else $error("line 5 not plain I/O in single chip");

   AST_L4_SINGLE: assert property (
      @(posedge SYS_CLK) disable iff (RST || HW_STANDBY)
      (CE && !expanded) |=> (P4_OE[4] == $past(s.p4_dir[4]) && P4_OUT[4] == $past(s.p4_latch[4])))
      else $error("line 4 not plain I/O in single chip");

   AST_L3_STROBE: assert property (
      @(posedge SYS_CLK) disable iff (RST || HW_STANDBY)
      (CE && expanded) |=> (P4_OE[3] && P4_OUT[3] == $past(STROBES.read_strobe_n)))
      else $error("line 3 read strobe wrong");

   AST_P5_TWO_WIRE: assert property (
      @(posedge SYS_CLK) disable iff (RST || HW_STANDBY)
      (CE && s.cfg.two_wire_enable && SERIAL0_IDLE) |=> (!P5_OUT[2] && P5_OE[2] == !$past(s.p5_latch[2])))
      else $error("port 5 line 2 not open drain");

   AST_P5_DATA_RST: assert property (
      @(posedge SYS_CLK) (RST || HW_STANDBY) |=> (s.p5_latch == pfio_pkg::P5_DATA_RST[pfio_pkg::P5_LINES-1:0]))
      else $error("port 5 latch not loaded on reset");

   AST_P4_READ: assert property (
      @(posedge SYS_CLK) disable iff (RST || HW_STANDBY)
      (CE && AVS_READ && !s.ack && idx == pfio_pkg::P4_DATA_IDX) |=>
         (AVS_READDATA[5:0] == (($past(s.p4_dir) & $past(s.p4_latch)) | (~$past(s.p4_dir) & $past(P4_IN)))))
      else $error("port 4 read value wrong");

   AST_MODE1_EXP: assert property (
      @(posedge SYS_CLK) disable iff (RST || HW_STANDBY)
      (CE && s.cfg.mode == pfio_pkg::MODE_EXP_ONLY) |=> (P4_OE[5:3] == 3'h7))
      else $error("mode 1 not treated as expanded");

endmodule

//--- design/pfio_pkg.sv
// shared constants and types for the port 4 low lines and port 5 I/O block
package pfio_pkg;

   // ==========================================================
   // register indices (byte address is four times the index)
   // ==========================================================
   localparam int ADDR_W = 18;
   localparam logic [15:0] P4_DIR_IDX = 16'hFFB5;
   localparam logic [15:0] P4_DATA_IDX = 16'hFFB7;
   localparam logic [15:0] P5_DIR_IDX = 16'hFFB8;
   localparam logic [15:0] P5_DATA_IDX = 16'hFFBA;
   localparam logic [15:0] CFG_IDX = 16'hFFC0;

   // ==========================================================
   // widths and reset values
   // ==========================================================
   localparam int P4_LINES = 6;
   localparam int P5_LINES = 3;
   localparam int P4_STROBE_LO = 3;
   localparam logic [7:0] P4_DIR_RST = 8'h00;
   localparam logic [7:0] P4_DATA_RST = 8'h00;
   localparam logic [7:0] P5_DIR_RST = 8'hF8;
   localparam logic [7:0] P5_DATA_RST = 8'hF8;
   localparam logic [4:0] P5_RSVD_ONES = 5'h1F;
   localparam logic [1:0] MODE_EXP_ONLY = 2'h1;
   localparam logic [1:0] CFG_BE_MASK = 2'h3;

   // ==========================================================
   // configuration register fields, bit 0 first
   // ==========================================================
   localparam int CFG_EBE_BIT = 0;
   localparam int CFG_MODE_LO_BIT = 1;
   localparam int CFG_IO_STROBE_SELECT_BIT = 3;
   localparam int CFG_INT_LO_BIT = 4;
   localparam int CFG_TRG_LO_BIT = 7;
   localparam int CFG_TRG_HI_BIT = 8;
   localparam int CFG_TW_BIT = 9;
   localparam int CFG_W = 10;

   typedef struct packed {
      logic two_wire_enable;
      logic trigger_select_hi;
      logic trigger_select_lo;
      logic [2:0] ext_int_enable;
      logic io_strobe_select;
      logic [1:0] mode;
      logic external_bus_enable;
   } pfio_cfg_t;

   // mode 3, single chip
   localparam logic [CFG_W-1:0] CFG_RST = 10'h006;

   // bus-control strobes from the bus controller, active low
   typedef struct packed {
      logic address_strobe_n;
      logic io_strobe_n;
      logic store_strobe_n;
      logic read_strobe_n;
   } pfio_strobe_t;

   typedef struct packed {
      pfio_cfg_t cfg;
      logic [P4_LINES-1:0] p4_dir;
      logic [P4_LINES-1:0] p4_latch;
      logic [7:0] p5_dir;
      logic [P5_LINES-1:0] p5_latch;
      logic ack;
      logic waitreq;
      logic [31:0] rdata;
      logic [P4_LINES-1:0] p4_out;
      logic [P4_LINES-1:0] p4_oe;
      logic [P5_LINES-1:0] p5_out;
      logic [P5_LINES-1:0] p5_oe;
      logic [2:0] ext_int_n;
      logic trig_n;
   } pfio_state_t;

endpackage

//--- design/pfio_p4_mux.sv
// pin function select for port 4 lines 5 to 0
`timescale 1ns/1ps
module pfio_p4_mux #(
   parameter int LINES = pfio_pkg::P4_LINES
) (
   // mode and strobes
   input wire logic expanded,
   input wire logic io_strobe_select,
   input wire pfio_pkg::pfio_strobe_t strobes,
   // port settings
   input wire logic [LINES-1:0] dir,
   input wire logic [LINES-1:0] latch,
   // pin drive
   output logic [LINES-1:0] out,
   output logic [LINES-1:0] oe
);
   logic [LINES-1:0] strobe_val;

   always_comb begin
      strobe_val = '1;
      // line 5 strobe pick
      // address or io strobe
      strobe_val[5] = io_strobe_select ? strobes.io_strobe_n : strobes.address_strobe_n;
      strobe_val[4] = strobes.store_strobe_n;
      strobe_val[3] = strobes.read_strobe_n;
   end

   genvar i;
   generate
      for (i = 0; i < LINES; i++) begin : g_line
         if (i >= pfio_pkg::P4_STROBE_LO) begin : g_strobe
            // strobe lines ignore direction when expanded
            assign out[i] = expanded ? strobe_val[i] : latch[i];
            assign oe[i] = expanded | dir[i];
         end else begin : g_plain
            assign out[i] = latch[i];
            assign oe[i] = dir[i];
         end
      end
   endgenerate
endmodule

//--- design/pfio_p5_mux.sv
// pin drive and read-back for port 5 lines 2 to 0
`timescale 1ns/1ps
module pfio_p5_mux #(
   parameter int LINES = pfio_pkg::P5_LINES
) (
   // settings
   input wire logic two_wire_enable,
   input wire logic serial_idle,
   input wire logic [LINES-1:0] dir,
   input wire logic [LINES-1:0] latch,
   input wire logic [LINES-1:0] pin,
   // pin drive and read value
   output logic [LINES-1:0] out,
   output logic [LINES-1:0] oe,
   output logic [LINES-1:0] rd
);
   genvar i;
   generate
      for (i = 0; i < LINES; i++) begin : g_line
         assign rd[i] = dir[i] ? latch[i] : pin[i];
         if (i == LINES - 1) begin : g_tw
            // two-wire open drain only pulls low
            assign out[i] = (two_wire_enable & serial_idle) ? 1'b0 : latch[i];
            assign oe[i] = (two_wire_enable & serial_idle) ? ~latch[i] : dir[i];
         end else begin : g_io
            assign out[i] = latch[i];
            assign oe[i] = dir[i];
         end
      end
   endgenerate
endmodule

//--- dv/pfio_pin_model.sv
// outside-world model of the port 4 and port 5 pins
`timescale 1ns/1ps
module pfio_pin_model (
   // device drive
   input wire logic [pfio_pkg::P4_LINES-1:0] p4_out,
   input wire logic [pfio_pkg::P4_LINES-1:0] p4_oe,
   input wire logic [pfio_pkg::P5_LINES-1:0] p5_out,
   input wire logic [pfio_pkg::P5_LINES-1:0] p5_oe,
   // levels the outside world applies
   input wire logic [pfio_pkg::P4_LINES-1:0] p4_ext,
   input wire logic [pfio_pkg::P5_LINES-1:0] p5_ext,
   // resolved pin levels
   output logic [pfio_pkg::P4_LINES-1:0] p4_pin,
   output logic [pfio_pkg::P5_LINES-1:0] p5_pin
);
   // =========================================
   // wire resolution
   // =========================================
   // a driven line shows the device value; a released one the outside level
   always_comb begin
      p4_pin = (p4_oe & p4_out) | (~p4_oe & p4_ext);
      p5_pin = (p5_oe & p5_out) | (~p5_oe & p5_ext);
   end
endmodule

//--- dv/pfio_tb.sv
// self-checking bench for the port 4 low lines and port 5 block
`timescale 1ns/1ps
module tb;
   localparam logic [15:0] DIR4 = pfio_pkg::P4_DIR_IDX;
   localparam logic [15:0] DAT4 = pfio_pkg::P4_DATA_IDX;
   localparam logic [15:0] DIR5 = pfio_pkg::P5_DIR_IDX;
   localparam logic [15:0] DAT5 = pfio_pkg::P5_DATA_IDX;
   localparam logic [15:0] CFG = pfio_pkg::CFG_IDX;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic hw_sb = 1'b0;
   logic [17:0] addr = '0;
   logic rd_en = 1'b0;
   logic wr_en = 1'b0;
   logic [31:0] wdata = '0;
   logic [3:0] be = '0;
   logic [31:0] rdata;
   logic waitreq;
   pfio_pkg::pfio_strobe_t strobes = '1;
   logic serial_idle = 1'b0;
   logic [5:0] ext4 = '0;
   logic [5:0] p4_pin, p4_out, p4_oe;
   logic [2:0] ext5 = 3'h2;
   logic [2:0] p5_pin, p5_out, p5_oe, int_n;
   logic trig_n;
   logic [7:0] dummy;
   int fails = 0;
   int compares = 0;

   always #2.5 clk = ~clk;

   pfio_top i_pfio_top (.SYS_CLK(clk), .RST(rst), .CE(ce), .HW_STANDBY(hw_sb), .AVS_ADDRESS(addr),
      .AVS_READ(rd_en), .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
      .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .STROBES(strobes), .SERIAL0_IDLE(serial_idle),
      .P4_IN(p4_pin), .P4_OUT(p4_out), .P4_OE(p4_oe), .P5_IN(p5_pin), .P5_OUT(p5_out), .P5_OE(p5_oe),
      .EXT_INT_PIN_N(int_n), .CONVERTER_TRIGGER_PIN_N(trig_n));

   pfio_pin_model i_pfio_pin_model (.p4_out(p4_out), .p4_oe(p4_oe), .p5_out(p5_out), .p5_oe(p5_oe),
      .p4_ext(ext4), .p5_ext(ext5), .p4_pin(p4_pin), .p5_pin(p5_pin));

   // =========================================
   // shared tasks
   // =========================================
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [15:0] idx, input logic [15:0] wd, input logic [3:0] ben,
                      output logic [7:0] rd);
      int n;
      @(posedge clk);
      addr <= {idx, 2'b00};
      wr_en <= wr;
      rd_en <= ~wr;
      wdata <= {16'h0000, wd};
      be <= ben;
      n = 0;
      @(posedge clk);
      while (waitreq !== 1'b0 && n < 40) begin
         n++;
         @(posedge clk);
      end
      if (n >= 40) fails++;
      rd = rdata[7:0];
      wr_en <= 1'b0;
      rd_en <= 1'b0;
   endtask

   task automatic wr(input logic [15:0] idx, input logic [15:0] wd);
      bus(1'b1, idx, wd, 4'hF, dummy);
   endtask

   task automatic rd_check(input logic [15:0] idx, input logic [7:0] exp);
      logic [7:0] v;
      bus(1'b0, idx, 16'h0000, 4'hF, v);
      check(v, exp);
   endtask

   // outputs are registered, pins resolve behind them
   task automatic look();
      repeat (3) @(negedge clk);
   endtask

   // =========================================
   // scenarios
   // =========================================
   task automatic t_reset();
      look();
      check(p5_oe, 3'h0);
      check(int_n, 3'h7);
      check(trig_n, 1'b1);
      rd_check(DAT5, 8'hFA);
   endtask

   task automatic t_port5();
      wr(DIR5, 16'h00FB);
      wr(DAT5, 16'h0002);
      look();
      check(p5_oe, 3'h3);
      check(p5_out[1:0], 2'h2);
      rd_check(DAT5, 8'hFA);
      wr(DAT5, 16'h0007);
      rd_check(DAT5, 8'hFB);
      wr(CFG, 16'h0007);
      look();
      check(p5_oe, 3'h3);
      rd_check(DAT5, 8'hFB);
      rd_check(DIR5, 8'h00);
      bus(1'b1, DIR5, 16'h0000, 4'h0, dummy);
      wr(16'hFFC4, 16'h00FF);
      rd_check(16'hFFC4, 8'h00);
      look();
      check(p5_oe, 3'h3);
   endtask

   task automatic t_port4_single();
      logic [15:0] cfgs [2] = '{16'h0006, 16'h0004};
      foreach (cfgs[i]) begin
         wr(CFG, cfgs[i]);
         wr(DIR4, 16'h003F);
         wr(DAT4, 16'h002A);
         look();
         check(p4_oe, 6'h3F);
         check(p4_out, 6'h2A);
         rd_check(DAT4, 8'h2A);
         @(posedge clk);
         ext4 <= 6'h15;
         wr(DIR4, 16'h0000);
         look();
         check(p4_oe, 6'h00);
         rd_check(DAT4, 8'h15);
      end
   endtask

   task automatic t_port4_expanded();
      logic [15:0] cfgs [4] = '{16'h0007, 16'h000F, 16'h0003, 16'h000A};
      logic [3:0] pats [2] = '{4'hA, 4'h5};
      foreach (cfgs[i]) begin
         wr(CFG, cfgs[i]);
         foreach (pats[j]) begin
            @(posedge clk);
            strobes <= pats[j];
            look();
            check(p4_oe, 6'h38);
            check(p4_out[5], cfgs[i][3] ? pats[j][2] : pats[j][3]);
            check(p4_out[4], pats[j][1]);
            check(p4_out[3], pats[j][0]);
         end
      end
   endtask

   task automatic t_int_trigger();
      wr(CFG, 16'h01F6);
      for (int p = 0; p < 8; p++) begin
         @(posedge clk);
         ext4 <= {3'h0, p[2:0]};
         look();
         check(int_n, {p[0], p[1], p[2]});
         check(trig_n, p[0]);
      end
      wr(CFG, 16'h0086);
      look();
      check(int_n, 3'h7);
      check(trig_n, 1'b1);
      wr(CFG, 16'h01F6);
      wr(DAT4, 16'h0000);
      wr(DIR4, 16'h0001);
      look();
      check(int_n[2], 1'b0);
      check(trig_n, 1'b0);
   endtask

   task automatic t_two_wire();
      @(posedge clk);
      serial_idle <= 1'b1;
      ext5 <= 3'h7;
      wr(CFG, 16'h0206);
      wr(DIR5, 16'h0004);
      wr(DAT5, 16'h0000);
      look();
      check({p5_oe[2], p5_out[2]}, 2'h2);
      wr(DAT5, 16'h0004);
      look();
      check(p5_oe[2], 1'b0);
   endtask

   task automatic t_standby();
      wr(CFG, 16'h0076);
      wr(DIR5, 16'h0003);
      @(posedge clk);
      ce <= 1'b0;
      ext5 <= 3'h2;
      ext4 <= 6'h00;
      repeat (6) @(posedge clk);
      check(int_n, 3'h3);
      ce <= 1'b1;
      look();
      check(p5_oe, 3'h3);
      check(int_n, 3'h0);
      @(posedge clk);
      hw_sb <= 1'b1;
      repeat (2) @(posedge clk);
      hw_sb <= 1'b0;
      look();
      check(p5_oe, 3'h0);
      rd_check(DAT5, 8'hFA);
      wr(DIR5, 16'h0007);
      rd_check(DAT5, 8'hF8);
   endtask

   // =========================================
   // verdict and run control
   // =========================================
   task automatic tally_and_finish();
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // whole run is a few hundred cycles; this bounds a hang
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      tally_and_finish();
   end

   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_port5();
      t_port4_single();
      t_port4_expanded();
      t_int_trigger();
      t_two_wire();
      t_standby();
      tally_and_finish();
   end
endmodule
